// file: rtl/rso_hold_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Retriggerable down-counter: busy while start is high and for LOAD cycles after it falls
module rso_hold_timer #(
	parameter logic [19:0] LOAD = 20'h00001
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      busy
);
	logic [19:0] count;
	logic [19:0] next_count;

	// Reload while start is active so the hold always counts from the end
	always_comb
	begin
		next_count = count;
		if (start)
			next_count = LOAD;
		else if (count != rso_pkg::CNT_ZERO)
			next_count = count - rso_pkg::CNT_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			count <= rso_pkg::CNT_ZERO;
		else
			count <= next_count;
	end

	assign busy = start || (count != rso_pkg::CNT_ZERO);
endmodule : rso_hold_timer
`default_nettype wire

// file: rtl/rso_pkg.sv
package rso_pkg;
	localparam int  CLK_PERIOD_NS = 10;
	localparam int  VID_HOLD_US   = 20;
	localparam int  STARTUP_MS    = 5;
	localparam int  VID_HOLD_CYC  = (VID_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  STARTUP_CYC   = (STARTUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  CNT_W         = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 20'h00001;
endpackage : rso_pkg

// file: rtl/rso_regulation_status.sv
`timescale 1ns/100ps
`default_nettype none
module rso_regulation_status #(
	parameter int STARTUP_CYCLES = rso_pkg::STARTUP_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic feedbackBelowUpper,
	input  wire logic feedbackAboveLower,
	input  wire logic shutdown,
	input  wire logic softStart,
	input  wire logic softStop,
	input  wire logic vidTransition,
	input  wire logic transitionDown,
	input  wire logic skipMode,
	input  wire logic slewBlanking,
	output logic      clockEnableDriveLowEn,
	output logic      powerGoodDriveLowEn
);
	typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_RUN} rso_state_t;
	rso_state_t state;
	rso_state_t next_state;
	logic [22:0] delayCnt;
	logic [22:0] next_delayCnt;
	logic        vidHold;
	logic        upperBlank;
	logic        next_upperBlank;
	logic        inWindow;
	logic        forcedHigh;
	logic        clkEnLow;
	logic        next_clkEnLow;
	logic        pgLow;
	logic        next_pgLow;
	localparam logic [22:0] START_LOAD = 23'(STARTUP_CYCLES);
	localparam logic [19:0] VID_TAIL   = 20'(rso_pkg::VID_HOLD_CYC);
	localparam logic [19:0] TAIL_MAX   = '1;
	logic [19:0] tailCnt;
	logic [19:0] next_tailCnt;

	// Transition plus the 20us tail after it
	rso_hold_timer #(
		.LOAD(20'(rso_pkg::VID_HOLD_CYC))
	) u_vidHold (
		.clk  (clk),
		.rst  (rst),
		.start(vidTransition),
		.busy (vidHold)
	);

	// Upper-threshold blanking latched for a skip-mode downward move
	always_comb
	begin
		next_upperBlank = upperBlank;
		if (skipMode && transitionDown && vidTransition)
			next_upperBlank = 1'b1;
		else if (!slewBlanking && !vidTransition)
			next_upperBlank = 1'b0;
	end

	// Blanking flag register; a set in the same cycle as a clear wins
	always_ff @(posedge clk)
	begin
		if (rst)
			upperBlank <= 1'b0;
		else
			upperBlank <= next_upperBlank;
	end

	assign inWindow   = feedbackAboveLower && (feedbackBelowUpper || upperBlank);
	assign forcedHigh = shutdown || softStart || softStop;

	// Clock-enable drive: forced states take priority over feedback
	always_comb
	begin
		if (forcedHigh)
			next_clkEnLow = 1'b0;
		else if (vidHold)
			next_clkEnLow = 1'b1;
		else
			next_clkEnLow = inWindow;
	end

	// Clock-enable drive register; comes out of reset released
	always_ff @(posedge clk)
	begin
		if (rst)
			clkEnLow <= 1'b0;
		else
			clkEnLow <= next_clkEnLow;
	end

	// Startup delay sequencer; rearmed whenever the output is forced off
	always_comb
	begin
		next_state    = state;
		next_delayCnt = delayCnt;
		next_pgLow    = 1'b1;
		unique case (state)
			ST_OFF:
			begin
				if (clkEnLow && !forcedHigh)
				begin
					next_state    = ST_DELAY;
					next_delayCnt = START_LOAD;
				end
			end
			ST_DELAY:
			begin
				next_delayCnt = delayCnt - 23'h000001;
				if (delayCnt == 23'h000001)
					next_state = ST_RUN;
			end
			ST_RUN:
				next_pgLow = !next_clkEnLow;
			// The fourth code is unused; fall back to the safe off state
			default:
				next_state = ST_OFF;
		endcase
		if (forcedHigh)
			next_state = ST_OFF;
	end

	// Sequencer and power-good registers; registering keeps the enables glitch free
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state    <= ST_OFF;
			delayCnt <= 23'h000000;
			pgLow    <= 1'b1;
		end
		else
		begin
			state    <= next_state;
			delayCnt <= next_delayCnt;
			pgLow    <= next_pgLow;
		end
	end

	// Enable high means pull the pin low; low means released to the pull-up
	assign clockEnableDriveLowEn = clkEnLow;
	assign powerGoodDriveLowEn   = pgLow;

	// Transition seen while nothing forces the output off
	sequence vidStart_s;
		vidTransition && !forcedHigh;
	endsequence

	// Skip-mode downward move that arms the upper-threshold blanking
	sequence skipDown_s;
		skipMode && transitionDown && vidTransition;
	endsequence

	// Still inside the post-transition tail, as counted by the helper below
	sequence tailOpen_s;
		!forcedHigh && tailCnt < VID_TAIL;
	endsequence

	// Checker helper: cycles since the last transition ended, saturating so it never wraps
	always_comb
	begin
		next_tailCnt = tailCnt;
		if (vidTransition)
			next_tailCnt = rso_pkg::CNT_ZERO;
		else if (tailCnt != TAIL_MAX)
			next_tailCnt = tailCnt + rso_pkg::CNT_ONE;
	end

	// Starts saturated so no tail is pending out of reset
	always_ff @(posedge clk)
	begin
		if (rst)
			tailCnt <= TAIL_MAX;
		else
			tailCnt <= next_tailCnt;
	end

	// Forced states win over everything else
	clock_enable_out_n_forced_a: assert property (@(posedge clk) disable iff (rst)
		forcedHigh |=> !clockEnableDriveLowEn) else $error("clock enable not released");

	clock_enable_out_n_vid_a: assert property (@(posedge clk) disable iff (rst)
		vidStart_s |=> clockEnableDriveLowEn) else $error("clock enable not low in transition");

	vid_tail_a: assert property (@(posedge clk) disable iff (rst)
		$fell(vidTransition) && !forcedHigh ##1 !forcedHigh[*8] |-> clockEnableDriveLowEn)
		else $error("transition hold too short");

	// The repetition above only covers the first cycles; the counter covers the whole tail
	vid_full_tail_a: assert property (@(posedge clk) disable iff (rst)
		tailOpen_s |=> clockEnableDriveLowEn) else $error("transition hold ended early");

	// Checked against the raw comparators so a broken window decode is caught
	clock_enable_out_n_win_a: assert property (@(posedge clk) disable iff (rst)
		!forcedHigh && !vidHold && !upperBlank |=>
		clockEnableDriveLowEn == $past(feedbackAboveLower && feedbackBelowUpper))
		else $error("clock enable does not follow window");

	pg_inverse_a: assert property (@(posedge clk) disable iff (rst)
		state == ST_RUN && $past(state) == ST_RUN |->
		powerGoodDriveLowEn == !clockEnableDriveLowEn)
		else $error("power good not inverse");

	pg_startup_a: assert property (@(posedge clk) disable iff (rst)
		state != ST_RUN |-> powerGoodDriveLowEn) else $error("power good early");

	// A forced state must pull power-good low again and rearm the delay
	pg_forced_a: assert property (@(posedge clk) disable iff (rst)
		forcedHigh |=> powerGoodDriveLowEn && state == ST_OFF)
		else $error("power good not held low");

	delay_enter_a: assert property (@(posedge clk) disable iff (rst)
		state == ST_OFF && clkEnLow && !forcedHigh |=> state == ST_DELAY && delayCnt == START_LOAD)
		else $error("startup delay not armed");

	delay_end_a: assert property (@(posedge clk) disable iff (rst)
		state == ST_DELAY && delayCnt == 23'h000001 && !forcedHigh |=> state == ST_RUN)
		else $error("startup delay not ended");

	skip_blank_a: assert property (@(posedge clk) disable iff (rst)
		skipDown_s |=> upperBlank)
		else $error("upper blanking not set");

	// While blanked only the lower threshold decides
	blank_hold_a: assert property (@(posedge clk) disable iff (rst)
		upperBlank && !forcedHigh && !vidHold |=>
		clockEnableDriveLowEn == $past(feedbackAboveLower))
		else $error("upper threshold not blanked");

	blank_clear_a: assert property (@(posedge clk) disable iff (rst)
		upperBlank && !slewBlanking && !vidTransition |=> !upperBlank)
		else $error("upper blanking not cleared");
endmodule : rso_regulation_status
`default_nettype wire

// file: testbench/rso_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host pull-ups on both open-drain pins
module rso_host_model (
	input  wire logic ceLow,
	input  wire logic pgLow,
	output logic      ceOut_n,
	output logic      pgOut
);
	// Released pin reads high; X passes through
	assign ceOut_n = ceLow ? 1'b0 : 1'b1;
	assign pgOut   = pgLow ? 1'b0 : 1'b1;
endmodule : rso_host_model
`default_nettype wire

// file: testbench/tb_regulation_status_outputs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_regulation_status_outputs;
	localparam int STARTUP = 20;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [8:0]  drv = 9'h001; // blank,skip,down,vid,aboveLo,belowUp,stop,start,shut
	logic        ceLow, pgLow, ceOut_n, pgOut;
	logic [1:0]  notes [$];
	logic [31:0] seed = 32'hec93fcfa;
	int          bad_count = 0;
	int          cmp_count = 0;
	event        look;
	// 100 MHz clock
	initial forever #5 clk = ~clk;
	rso_regulation_status #(.STARTUP_CYCLES(STARTUP)) dut_u (.clk(clk), .rst(rst),
		.shutdown(drv[0]), .softStart(drv[1]), .softStop(drv[2]),
		.feedbackBelowUpper(drv[3]), .feedbackAboveLower(drv[4]),
		.vidTransition(drv[5]), .transitionDown(drv[6]), .skipMode(drv[7]),
		.slewBlanking(drv[8]), .clockEnableDriveLowEn(ceLow), .powerGoodDriveLowEn(pgLow));
	rso_host_model host_u (.ceLow(ceLow), .pgLow(pgLow), .ceOut_n(ceOut_n), .pgOut(pgOut));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic compare(input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : compare
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	// Drive, let n edges pass, note expected pin levels
	task automatic step(input logic [8:0] v, input int n, input logic ce_n, input logic pg);
		drv <= v;
		repeat (n) @(posedge clk);
		notes.push_back({ce_n, pg});
		->look;
	endtask : step
	// Oldest note first; wait past the edge so registered outputs have landed
	always @(look)
	begin : watch
		logic [1:0] note;
		#1;
		note = notes.pop_front();
		compare(ceOut_n, note[1]);
		compare(pgOut, note[0]);
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		step(9'h019, 3, 1'b1, 1'b0);
		step(9'h018, 5, 1'b0, 1'b0);
		step(9'h018, STARTUP + 5, 1'b0, 1'b1);
		repeat (6)
		begin
			seed = lfsr(seed);
			step({4'h0, seed[1:0], 3'h0}, 3, ~&seed[1:0], &seed[1:0]);
		end
		step(9'h030, 3, 1'b0, 1'b1);
		step(9'h010, 1990, 1'b0, 1'b1);
		step(9'h010, 20, 1'b1, 1'b0);
		// Skip-mode downward move: upper limit ignored while blanking lasts
		step(9'h1f0, 3, 1'b0, 1'b1);
		step(9'h1d0, 2100, 1'b0, 1'b1);
		step(9'h0d0, 3, 1'b1, 1'b0);
		// Mid-run reset: both pins back to reset levels, startup rearmed
		rst <= 1'b1;
		step(9'h018, 2, 1'b1, 1'b0);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			step(9'h018 | (9'h001 << i), 3, 1'b1, 1'b0);
			step(9'h018, 5, 1'b0, 1'b0);
		end
		// Let the watcher take the last note before closing
		repeat (2) @(posedge clk);
		final_report();
	end
	// About 4200 cycles needed; generous margin
	initial
	begin
		#200000;
		bad_count++;
		final_report();
	end
endmodule : tb_regulation_status_outputs
`default_nettype wire
